// File: include/bpcr_pkg.sv
// constants for the buck-pair configuration register bank
// assumes one 8-bit register port, byte offsets as printed
`default_nettype none
package bpcr_pkg;
  localparam int BPCR_ADDR_W = 8;
  localparam int BPCR_DATA_W = 8;
  localparam int BPCR_VOLT_W = 6;
  localparam int BPCR_MODE_W = 4;
  localparam int BPCR_NUM_CONV = 2;
  // register offsets
  localparam logic [7:0] BPCR_OFF_A_SLEEP = 8'h3E;
  localparam logic [7:0] BPCR_OFF_A_MODE = 8'h3F;
  localparam logic [7:0] BPCR_OFF_A_CONF = 8'h40;
  localparam logic [7:0] BPCR_OFF_B_RUN = 8'h43;
  localparam logic [7:0] BPCR_OFF_B_STBY = 8'h44;
  localparam logic [7:0] BPCR_OFF_B_SLEEP = 8'h45;
  localparam logic [7:0] BPCR_OFF_B_MODE = 8'h46;
  localparam logic [7:0] BPCR_OFF_B_CONF = 8'h47;
  // field positions
  localparam int BPCR_VOLT_LSB = 0;
  localparam int BPCR_RANGE_BIT = 6;
  localparam int BPCR_MODE_LSB = 0;
  localparam int BPCR_SLEEP_BEH_BIT = 5;
  localparam int BPCR_ILIM_BIT = 0;
  localparam int BPCR_SPARE_BIT = 1;
  localparam int BPCR_FREQ_LSB = 2;
  localparam int BPCR_PHASE_LSB = 4;
  localparam int BPCR_SLEW_LSB = 6;
  // reset values
  localparam logic [5:0] BPCR_RST_VOLT = 6'h00;
  localparam logic [3:0] BPCR_RST_MODE = 4'h0;
  localparam logic BPCR_RST_SLEEP_BEH = 1'b0;
  localparam logic [7:0] BPCR_RST_CONF = 8'h00;
  localparam logic BPCR_RST_RANGE = 1'b0;
  localparam logic [7:0] BPCR_RD_IDLE = 8'h00;
endpackage
`default_nettype wire

// File: include/bpcr_range_if.sv
// carrier between the register bank and its range-bit latch
// assumes both ends on the same clock
`default_nettype none
interface bpcr_range_if;
  logic load;
  logic a_range_in;
  logic b_range_in;
  logic a_range;
  logic b_range;
  modport bank (output load, output a_range_in, output b_range_in, input a_range, input b_range);
  modport latch (input load, input a_range_in, input b_range_in, output a_range, output b_range);
endinterface
`default_nettype wire

// File: verilog/bpcr_range_latch.sv
// range bits fixed by one-time or test-board configuration
// assumes load is a one-cycle pulse from logic on clk
`default_nettype none
module bpcr_range_latch
  import bpcr_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  bpcr_range_if.latch rng
);
  logic a_range_r;
  logic b_range_r;

  // only sys_rst and the configuration load move these; register writes never reach them
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      a_range_r <= BPCR_RST_RANGE;
      b_range_r <= BPCR_RST_RANGE;
    end
    else if (rng.load)
    begin
      a_range_r <= rng.a_range_in; // RL2
      b_range_r <= rng.b_range_in; // RL10
    end
  end

  assign rng.a_range = a_range_r;
  assign rng.b_range = b_range_r;
endmodule
`default_nettype wire

// File: verilog/bpcr_regs.sv
// register bank for the buck converter pair A/B
// assumes a same-clock register port and a same-clock configuration loader
//
// Contract
// RL1 - A sleep register holds 6-bit sleep voltage
// RL2 - A sleep bit 6 mirrors A range
// RL3 - A mode register holds 4-bit switch mode
// RL4 - A mode bit 5 sleep off/pfm
// RL5 - A config bit 0 selects current limit
// RL6 - A config bits 3:2 frequency, reset zero
// RL7 - A config bits 5:4 phase clock, reset zero
// RL8 - A config bits 7:6 slew speed, reset zero
// RL9 - B run register holds 6-bit voltage
// RL10 - B run bit 6 read-only range bit
// RL11 - B standby register holds 6-bit voltage
// RL12 - B standby bit 6 mirrors B range
// RL13 - B sleep register holds 6-bit voltage
// RL14 - B sleep bit 6 mirrors B range
// RL15 - B mode register holds 4-bit switch mode
// RL16 - B mode bit 5 sleep off/pfm
// RL17 - B config bit 0 limit, bit 1 spare
// RL18 - B config frequency, phase, slew fields
// RL19 - software uses codes 0..63 below 2V
// RL20 - unused bits read zero, ignore writes; the spare bit 1 of each config register is stored and read back
`default_nettype none
module bpcr_regs
  import bpcr_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [bpcr_pkg::BPCR_ADDR_W-1:0] reg_addr,
  input wire logic reg_wr_en,
  input wire logic [bpcr_pkg::BPCR_DATA_W-1:0] reg_wr_data,
  input wire logic reg_rd_en,
  output logic [bpcr_pkg::BPCR_DATA_W-1:0] reg_rd_data,
  output logic reg_rd_valid,
  input wire logic otp_range_load,
  input wire logic otp_a_range,
  input wire logic otp_b_range,
  output logic [bpcr_pkg::BPCR_VOLT_W-1:0] buck_a_sleep_voltage_field,
  output logic [bpcr_pkg::BPCR_VOLT_W-1:0] buck_b_run_voltage_field,
  output logic [bpcr_pkg::BPCR_VOLT_W-1:0] buck_b_standby_voltage_field,
  output logic [bpcr_pkg::BPCR_VOLT_W-1:0] buck_b_sleep_voltage_field,
  output logic buck_a_range_bit,
  output logic buck_b_range_bit,
  output logic [bpcr_pkg::BPCR_MODE_W-1:0] buck_a_switch_mode_field,
  output logic [bpcr_pkg::BPCR_MODE_W-1:0] buck_b_switch_mode_field,
  output logic buck_a_sleep_behaviour_bit,
  output logic buck_b_sleep_behaviour_bit,
  output logic buck_a_current_limit_bit,
  output logic buck_b_current_limit_bit,
  output logic [1:0] buck_a_frequency_field,
  output logic [1:0] buck_b_frequency_field,
  output logic [1:0] buck_a_phase_clock_field,
  output logic [1:0] buck_b_phase_clock_field,
  output logic [1:0] buck_a_slew_speed_field,
  output logic [1:0] buck_b_slew_speed_field
);
  import bpcr_pkg::*;

  localparam logic [7:0] MODE_OFF [BPCR_NUM_CONV] = '{BPCR_OFF_A_MODE, BPCR_OFF_B_MODE};
  localparam logic [7:0] CONF_OFF [BPCR_NUM_CONV] = '{BPCR_OFF_A_CONF, BPCR_OFF_B_CONF};

  function automatic logic bpcr_wr_hit(input logic en, input logic [7:0] addr, input logic [7:0] off);
    bpcr_wr_hit = en && (addr == off);
  endfunction

  // a voltage byte: 6-bit code, range bit above, bit 7 zero
  function automatic logic [7:0] bpcr_volt_byte(input logic [5:0] code, input logic range);
    bpcr_volt_byte = {1'b0, range, code};
  endfunction

  bpcr_range_if rng ();

  logic [BPCR_VOLT_W-1:0] a_sleep_r;
  logic [BPCR_VOLT_W-1:0] b_run_r;
  logic [BPCR_VOLT_W-1:0] b_stby_r;
  logic [BPCR_VOLT_W-1:0] b_sleep_r;
  logic [BPCR_MODE_W-1:0] mode_r [BPCR_NUM_CONV];
  logic sleep_beh_r [BPCR_NUM_CONV];
  logic [BPCR_DATA_W-1:0] conf_r [BPCR_NUM_CONV];
  logic [BPCR_DATA_W-1:0] rd_data_r;
  logic [BPCR_DATA_W-1:0] rd_nxt;
  logic rd_valid_r;

  assign rng.load = otp_range_load;
  assign rng.a_range_in = otp_a_range;
  assign rng.b_range_in = otp_b_range;

  bpcr_range_latch u_range (
    .clk(clk),
    .sys_rst(sys_rst),
    .rng(rng)
  );

  // voltage code registers; bit 6 of each write is dropped
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      a_sleep_r <= BPCR_RST_VOLT;
      b_run_r <= BPCR_RST_VOLT;
      b_stby_r <= BPCR_RST_VOLT;
      b_sleep_r <= BPCR_RST_VOLT;
    end
    else
    begin
      if (bpcr_wr_hit(reg_wr_en, reg_addr, BPCR_OFF_A_SLEEP))
        a_sleep_r <= reg_wr_data[BPCR_VOLT_LSB +: BPCR_VOLT_W]; // RL1
      if (bpcr_wr_hit(reg_wr_en, reg_addr, BPCR_OFF_B_RUN))
        b_run_r <= reg_wr_data[BPCR_VOLT_LSB +: BPCR_VOLT_W]; // RL9
      if (bpcr_wr_hit(reg_wr_en, reg_addr, BPCR_OFF_B_STBY))
        b_stby_r <= reg_wr_data[BPCR_VOLT_LSB +: BPCR_VOLT_W]; // RL11
      if (bpcr_wr_hit(reg_wr_en, reg_addr, BPCR_OFF_B_SLEEP))
        b_sleep_r <= reg_wr_data[BPCR_VOLT_LSB +: BPCR_VOLT_W]; // RL13
    end
  end

  // mode and configuration registers, one pair per converter
  for (genvar i = 0; i < BPCR_NUM_CONV; i++)
  begin : g_conv
    always_ff @(posedge clk)
    begin
      if (sys_rst)
      begin
        mode_r[i] <= BPCR_RST_MODE;
        sleep_beh_r[i] <= BPCR_RST_SLEEP_BEH;
      end
      else if (bpcr_wr_hit(reg_wr_en, reg_addr, MODE_OFF[i]))
      begin
        mode_r[i] <= reg_wr_data[BPCR_MODE_LSB +: BPCR_MODE_W]; // RL3 RL15
        sleep_beh_r[i] <= reg_wr_data[BPCR_SLEEP_BEH_BIT]; // RL4 RL16
      end
    end

    // every bit is writable here, the spare bit 1 included
    always_ff @(posedge clk)
    begin
      if (sys_rst)
        conf_r[i] <= BPCR_RST_CONF; // RL6 RL7 RL8 RL18
      else if (bpcr_wr_hit(reg_wr_en, reg_addr, CONF_OFF[i]))
        conf_r[i] <= reg_wr_data; // RL5 RL17 RL18 RL20
    end
  end

  // read mux; range bits come from the latch, unused bits as zero
  always_comb
  begin
    rd_nxt = BPCR_RD_IDLE;
    case (reg_addr)
      BPCR_OFF_A_SLEEP: rd_nxt = bpcr_volt_byte(a_sleep_r, rng.a_range); // RL2
      BPCR_OFF_B_RUN: rd_nxt = bpcr_volt_byte(b_run_r, rng.b_range); // RL10
      BPCR_OFF_B_STBY: rd_nxt = bpcr_volt_byte(b_stby_r, rng.b_range); // RL12
      BPCR_OFF_B_SLEEP: rd_nxt = bpcr_volt_byte(b_sleep_r, rng.b_range); // RL14
      BPCR_OFF_A_MODE: rd_nxt = {2'h0, sleep_beh_r[0], 1'b0, mode_r[0]}; // RL20
      BPCR_OFF_B_MODE: rd_nxt = {2'h0, sleep_beh_r[1], 1'b0, mode_r[1]}; // RL20
      BPCR_OFF_A_CONF: rd_nxt = conf_r[0];
      BPCR_OFF_B_CONF: rd_nxt = conf_r[1];
      default: rd_nxt = BPCR_RD_IDLE; // RL20
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      rd_data_r <= BPCR_RD_IDLE;
      rd_valid_r <= 1'b0;
    end
    else
    begin
      rd_valid_r <= reg_rd_en;
      if (reg_rd_en)
        rd_data_r <= rd_nxt;
    end
  end

  assign reg_rd_data = rd_data_r;
  assign reg_rd_valid = rd_valid_r;
  assign buck_a_sleep_voltage_field = a_sleep_r;
  assign buck_b_run_voltage_field = b_run_r;
  assign buck_b_standby_voltage_field = b_stby_r;
  assign buck_b_sleep_voltage_field = b_sleep_r;
  assign buck_a_range_bit = rng.a_range;
  assign buck_b_range_bit = rng.b_range;
  assign buck_a_switch_mode_field = mode_r[0];
  assign buck_b_switch_mode_field = mode_r[1];
  assign buck_a_sleep_behaviour_bit = sleep_beh_r[0];
  assign buck_b_sleep_behaviour_bit = sleep_beh_r[1];
  assign buck_a_current_limit_bit = conf_r[0][BPCR_ILIM_BIT];
  assign buck_b_current_limit_bit = conf_r[1][BPCR_ILIM_BIT];
  assign buck_a_frequency_field = conf_r[0][BPCR_FREQ_LSB +: 2];
  assign buck_b_frequency_field = conf_r[1][BPCR_FREQ_LSB +: 2];
  assign buck_a_phase_clock_field = conf_r[0][BPCR_PHASE_LSB +: 2];
  assign buck_b_phase_clock_field = conf_r[1][BPCR_PHASE_LSB +: 2];
  assign buck_a_slew_speed_field = conf_r[0][BPCR_SLEW_LSB +: 2];
  assign buck_b_slew_speed_field = conf_r[1][BPCR_SLEW_LSB +: 2];

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  property p_a_sleep_store;
    reg_wr_en && reg_addr == BPCR_OFF_A_SLEEP |=> buck_a_sleep_voltage_field == $past(reg_wr_data[5:0]);
  endproperty
  a_a_sleep_store: assert property (p_a_sleep_store) // RL1
    else $error("a sleep code not stored");

  property p_a_sleep_range_rd;
    reg_rd_en && reg_addr == BPCR_OFF_A_SLEEP && !otp_range_load |=> reg_rd_valid && reg_rd_data[6] == buck_a_range_bit;
  endproperty
  a_a_sleep_range_rd: assert property (p_a_sleep_range_rd) // RL2
    else $error("a sleep range bit wrong");

  property p_a_mode_store;
    reg_wr_en && reg_addr == BPCR_OFF_A_MODE
      |=> buck_a_switch_mode_field == $past(reg_wr_data[3:0]) && buck_a_sleep_behaviour_bit == $past(reg_wr_data[5]);
  endproperty
  a_a_mode_store: assert property (p_a_mode_store) // RL3 RL4
    else $error("a mode not stored");

  property p_a_conf_store;
    reg_wr_en && reg_addr == BPCR_OFF_A_CONF
      |=> {buck_a_slew_speed_field, buck_a_phase_clock_field, buck_a_frequency_field} == $past(reg_wr_data[7:2])
          && buck_a_current_limit_bit == $past(reg_wr_data[0]);
  endproperty
  a_a_conf_store: assert property (p_a_conf_store) // RL5 RL6 RL7 RL8
    else $error("a config not stored");

  property p_conf_reset;
    disable iff (1'b0) sys_rst |=> buck_a_frequency_field == 2'h0 && buck_b_slew_speed_field == 2'h0
      && buck_a_phase_clock_field == 2'h0 && buck_b_run_voltage_field == 6'h00;
  endproperty
  a_conf_reset: assert property (p_conf_reset) // RL6 RL9 RL18
    else $error("fields not zero after reset");

  property p_b_run_store;
    reg_wr_en && reg_addr == BPCR_OFF_B_RUN |=> buck_b_run_voltage_field == $past(reg_wr_data[5:0]);
  endproperty
  a_b_run_store: assert property (p_b_run_store) // RL9
    else $error("b run code not stored");

  property p_range_readonly;
    !otp_range_load |=> $stable(buck_b_range_bit) && $stable(buck_a_range_bit);
  endproperty
  a_range_readonly: assert property (p_range_readonly) // RL10 RL2
    else $error("range bit moved without load");

  property p_b_stby_rd;
    reg_rd_en && reg_addr == BPCR_OFF_B_STBY && !reg_wr_en && !otp_range_load
      |=> reg_rd_data == {1'b0, buck_b_range_bit, buck_b_standby_voltage_field};
  endproperty
  a_b_stby_rd: assert property (p_b_stby_rd) // RL11 RL12
    else $error("b standby read wrong");

  property p_b_sleep_rd;
    reg_rd_en && reg_addr == BPCR_OFF_B_SLEEP && !reg_wr_en && !otp_range_load
      |=> reg_rd_data == {1'b0, buck_b_range_bit, buck_b_sleep_voltage_field};
  endproperty
  a_b_sleep_rd: assert property (p_b_sleep_rd) // RL13 RL14
    else $error("b sleep read wrong");

  property p_b_mode_rd;
    reg_wr_en && reg_addr == BPCR_OFF_B_MODE ##1 reg_rd_en && reg_addr == BPCR_OFF_B_MODE && !reg_wr_en
      |=> reg_rd_data == ($past(reg_wr_data, 2) & 8'h2F);
  endproperty
  a_b_mode_rd: assert property (p_b_mode_rd) // RL15 RL16 RL20
    else $error("b mode readback wrong");

  property p_b_conf_rd;
    reg_wr_en && reg_addr == BPCR_OFF_B_CONF ##1 reg_rd_en && reg_addr == BPCR_OFF_B_CONF && !reg_wr_en
      |=> reg_rd_data == $past(reg_wr_data, 2);
  endproperty
  a_b_conf_rd: assert property (p_b_conf_rd) // RL17 RL18
    else $error("b config readback wrong");

  property p_b_mode_store;
    reg_wr_en && reg_addr == BPCR_OFF_B_MODE
      |=> buck_b_switch_mode_field == $past(reg_wr_data[3:0]) && buck_b_sleep_behaviour_bit == $past(reg_wr_data[5]);
  endproperty
  a_b_mode_store: assert property (p_b_mode_store) // RL15 RL16
    else $error("b mode not stored");

  property p_b_conf_store;
    reg_wr_en && reg_addr == BPCR_OFF_B_CONF
      |=> {buck_b_slew_speed_field, buck_b_phase_clock_field, buck_b_frequency_field} == $past(reg_wr_data[7:2])
          && buck_b_current_limit_bit == $past(reg_wr_data[0]);
  endproperty
  a_b_conf_store: assert property (p_b_conf_store) // RL17 RL18
    else $error("b config not stored");

  property p_hole_wr_ignored;
    reg_wr_en && (reg_addr == 8'h3C || reg_addr == 8'h3D || reg_addr == 8'h41 || reg_addr == 8'h42)
      |=> $stable(buck_a_sleep_voltage_field) && $stable(buck_b_run_voltage_field)
          && $stable(buck_a_switch_mode_field) && $stable(buck_b_slew_speed_field);
  endproperty
  a_hole_wr_ignored: assert property (p_hole_wr_ignored) // RL20
    else $error("unmapped write changed a field");

  property p_unmapped_rd;
    reg_rd_en && (reg_addr < BPCR_OFF_A_SLEEP || reg_addr > BPCR_OFF_B_CONF
      || reg_addr == 8'h41 || reg_addr == 8'h42) |=> reg_rd_valid && reg_rd_data == 8'h00;
  endproperty
  a_unmapped_rd: assert property (p_unmapped_rd) // RL20
    else $error("unmapped read not zero");

  property p_rd_valid_timing;
    reg_rd_en |=> reg_rd_valid ##1 (reg_rd_valid == $past(reg_rd_en));
  endproperty
  a_rd_valid_timing: assert property (p_rd_valid_timing)
    else $error("read valid timing wrong");

  c_a_sleep_wr: cover property (reg_wr_en && reg_addr == BPCR_OFF_A_SLEEP);
  c_range_load: cover property (otp_range_load ##1 buck_b_range_bit);
  c_b_conf_wr_rd: cover property (reg_wr_en && reg_addr == BPCR_OFF_B_CONF ##1 reg_rd_en && reg_addr == BPCR_OFF_B_CONF);
  c_unmapped_rd: cover property (reg_rd_en && reg_addr == 8'h3C);
endmodule
`default_nettype wire

// File: dv/testbench.sv
// self-checking bench for the buck-pair register bank
// assumes bpcr_pkg and the bank with its range latch are compiled first
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import bpcr_pkg::*;

  localparam logic [7:0] OFFS [8] = '{BPCR_OFF_A_SLEEP, BPCR_OFF_A_MODE, BPCR_OFF_A_CONF, BPCR_OFF_B_RUN,
    BPCR_OFF_B_STBY, BPCR_OFF_B_SLEEP, BPCR_OFF_B_MODE, BPCR_OFF_B_CONF};
  localparam logic [7:0] HOLES [4] = '{8'h3C, 8'h3D, 8'h41, 8'h42};

  logic clk;
  logic sys_rst;
  logic [7:0] reg_addr;
  logic reg_wr_en;
  logic [7:0] reg_wr_data;
  logic reg_rd_en;
  logic [7:0] reg_rd_data;
  logic reg_rd_valid;
  logic otp_range_load;
  logic otp_a_range;
  logic otp_b_range;
  logic [5:0] a_sleep, b_run, b_stby, b_sleep;
  logic a_rng, b_rng, a_beh, b_beh, a_ilim, b_ilim;
  logic [3:0] a_mode, b_mode;
  logic [1:0] a_freq, b_freq, a_phase, b_phase, a_slew, b_slew;
  logic [7:0] wv [8];
  int fails = 0;
  int checks_done = 0;

  bpcr_regs u_bpcr_regs (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wr_en(reg_wr_en),
    .reg_wr_data(reg_wr_data), .reg_rd_en(reg_rd_en), .reg_rd_data(reg_rd_data), .reg_rd_valid(reg_rd_valid),
    .otp_range_load(otp_range_load), .otp_a_range(otp_a_range), .otp_b_range(otp_b_range),
    .buck_a_sleep_voltage_field(a_sleep), .buck_b_run_voltage_field(b_run),
    .buck_b_standby_voltage_field(b_stby), .buck_b_sleep_voltage_field(b_sleep),
    .buck_a_range_bit(a_rng), .buck_b_range_bit(b_rng), .buck_a_switch_mode_field(a_mode),
    .buck_b_switch_mode_field(b_mode), .buck_a_sleep_behaviour_bit(a_beh), .buck_b_sleep_behaviour_bit(b_beh),
    .buck_a_current_limit_bit(a_ilim), .buck_b_current_limit_bit(b_ilim), .buck_a_frequency_field(a_freq),
    .buck_b_frequency_field(b_freq), .buck_a_phase_clock_field(a_phase), .buck_b_phase_clock_field(b_phase),
    .buck_a_slew_speed_field(a_slew), .buck_b_slew_speed_field(b_slew));

  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic give_verdict;
    $display("checks_done=%0d fails=%0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr_en <= 1'b1;
    reg_addr <= a;
    reg_wr_data <= d;
    @(posedge clk);
    reg_wr_en <= 1'b0;
  endtask

  // read answer is sampled just after the edge that takes the request
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    reg_rd_en <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd_en <= 1'b0;
    #1;
    check($sformatf("valid %h", a), {7'h00, reg_rd_valid}, 8'h01);
    check($sformatf("rd %h", a), reg_rd_data, exp);
  endtask

  // write, then read the same register on the very next cycle
  task automatic wr_rd(input logic [7:0] a, input logic [7:0] d, input logic [7:0] exp);
    @(posedge clk);
    reg_wr_en <= 1'b1;
    reg_addr <= a;
    reg_wr_data <= d;
    @(posedge clk);
    reg_wr_en <= 1'b0;
    reg_rd_en <= 1'b1;
    @(posedge clk);
    reg_rd_en <= 1'b0;
    #1;
    check($sformatf("b2b %h", a), reg_rd_data, exp);
  endtask

  // inputs flip after the pulse so a bank that tracks them is caught
  task automatic load_range(input logic ra, input logic rb);
    @(posedge clk);
    otp_range_load <= 1'b1;
    otp_a_range <= ra;
    otp_b_range <= rb;
    @(posedge clk);
    otp_range_load <= 1'b0;
    otp_a_range <= ~ra;
    otp_b_range <= ~rb;
    repeat (2) @(posedge clk);
    #1;
    check("ranges", {6'h00, a_rng, b_rng}, {6'h00, ra, rb});
  endtask

  function automatic logic [7:0] expect_rd(input int i, input logic [7:0] d, input logic ra, input logic rb);
    if (i == 1 || i == 6)
      return {2'b00, d[5], 1'b0, d[3:0]};
    if (i == 2 || i == 7)
      return d;
    return {1'b0, (i == 0) ? ra : rb, d[5:0]};
  endfunction

  task automatic pass_all(input logic [7:0] d, input logic ra, input logic rb);
    for (int i = 0; i < 8; i++)
    begin
      wv[i] = d ^ {5'h00, 3'(i)};
      wr(OFFS[i], wv[i]);
    end
    for (int i = 0; i < 4; i++)
      wr(HOLES[i], ~d);
    for (int i = 0; i < 8; i++)
      rd(OFFS[i], expect_rd(i, wv[i], ra, rb));
    for (int i = 0; i < 4; i++)
      rd(HOLES[i], 8'h00);
    check("a_sleep", {2'b00, a_sleep}, {2'b00, wv[0][5:0]});
    check("a_mode", {3'b000, a_beh, a_mode}, {3'b000, wv[1][5], wv[1][3:0]});
    check("a_conf", {a_slew, a_phase, a_freq, 1'b0, a_ilim}, {wv[2][7:2], 1'b0, wv[2][0]});
    check("b_run", {2'b00, b_run}, {2'b00, wv[3][5:0]});
    check("b_stby", {2'b00, b_stby}, {2'b00, wv[4][5:0]});
    check("b_sleep", {2'b00, b_sleep}, {2'b00, wv[5][5:0]});
    check("b_mode", {3'b000, b_beh, b_mode}, {3'b000, wv[6][5], wv[6][3:0]});
    check("b_conf", {b_slew, b_phase, b_freq, 1'b0, b_ilim}, {wv[7][7:2], 1'b0, wv[7][0]});
  endtask

  initial
  begin
    repeat (20000) @(posedge clk);
    fails++;
    give_verdict();
  end

  initial
  begin
    sys_rst = 1'b1;
    reg_addr = 8'h00;
    reg_wr_en = 1'b0;
    reg_wr_data = 8'h00;
    reg_rd_en = 1'b0;
    otp_range_load = 1'b0;
    otp_a_range = 1'b1;
    otp_b_range = 1'b1;
    repeat (4) @(posedge clk);
    sys_rst <= 1'b0;
    for (int i = 0; i < 8; i++)
      rd(OFFS[i], 8'h00);
    load_range(1'b1, 1'b0);
    pass_all(8'hFF, 1'b1, 1'b0);
    pass_all(8'hAA, 1'b1, 1'b0);
    load_range(1'b0, 1'b1);
    pass_all(8'h55, 1'b0, 1'b1);
    // read and write of one register in one cycle: read sees the old byte
    @(posedge clk);
    reg_rd_en <= 1'b1;
    reg_wr_en <= 1'b1;
    reg_addr <= BPCR_OFF_A_CONF;
    reg_wr_data <= ~wv[2];
    @(posedge clk);
    reg_rd_en <= 1'b0;
    reg_wr_en <= 1'b0;
    #1;
    check("rw_same", reg_rd_data, wv[2]);
    rd(BPCR_OFF_A_CONF, ~wv[2]);
    repeat (3) @(posedge clk);
    #1;
    check("valid_drop", {7'h00, reg_rd_valid}, 8'h00);
    check("rd_hold", reg_rd_data, ~wv[2]);
    wr_rd(BPCR_OFF_B_MODE, 8'hFF, 8'h2F);
    wr_rd(BPCR_OFF_B_CONF, 8'hC3, 8'hC3);
    // second reset in mid-run clears fields and range bits
    @(posedge clk);
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    for (int i = 0; i < 8; i++)
      rd(OFFS[i], 8'h00);
    check("rst_ranges", {6'h00, a_rng, b_rng}, 8'h00);
    give_verdict();
  end
endmodule
`default_nettype wire
